// ==== src/sarseq_params.svh ====
// timing constants and field sizes for the conversion sequencer
// assumes a single 40 MHz clock feeding the including module
`ifndef SARSEQ_PARAMS_SVH
`define SARSEQ_PARAMS_SVH
`define SARSEQ_CLK_PERIOD_PS 25000
`define SARSEQ_ACQ_MIN_NS    50
`define SARSEQ_ACQ_CYC       ((`SARSEQ_ACQ_MIN_NS * 1000 + `SARSEQ_CLK_PERIOD_PS - 1) / `SARSEQ_CLK_PERIOD_PS)
`define SARSEQ_RES_BITS      12
`define SARSEQ_RESULT_RST    12'h000
`endif

// ==== src/sarseq_pkg.sv ====
// types shared by the conversion sequencer
// assumes the params header is included first
`include "sarseq_params.svh"
package sarseq_pkg;
  typedef enum logic [1:0] {
    SARSEQ_ACQ,
    SARSEQ_CONV,
    SARSEQ_LOAD
  } sarseq_state_t;
  // analog side: sample strobe, comparator mode and bit trial
  typedef struct packed {
    logic                        sample;
    logic                        zeroing;
    logic [`SARSEQ_RES_BITS-1:0] trial;
  } sarseq_ana_t;
endpackage

// ==== src/sarseq_core.sv ====
// conversion sequencer of a 12-bit successive-approximation converter
// assumes pin inputs are asynchronous and the comparator answers within one cycle
//
// Notes on behaviour
// - start needs chip select and start input
// - conversion begins on start falling edge
// - start ignored unless chip select low
// - approximation register cleared at conversion start
// - starts ignored while conversion running
// - twelve bits decided, msb first, one per step
// - acquire phase at least 50 ns long
// - comparator zeroing only during acquire phase
// - full result loaded into output latches at end
// - both inputs sampled at one common instant
// - busy low throughout conversion, high when done
// - result presented as straight binary, the decided word unchanged
`timescale 1ns/1ps
`include "sarseq_params.svh"
module sarseq_core #(
  parameter int RES_BITS = `SARSEQ_RES_BITS,
  parameter int ACQ_CYC  = `SARSEQ_ACQ_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    conversion_start_n_i,
  input  wire logic                    comp_i,
  output logic                         busy_o,
  output logic [RES_BITS-1:0]          data_o,
  output sarseq_pkg::sarseq_ana_t      ana_o
);
  import sarseq_pkg::*;

  // elaboration check: the comparator walk and the output latches
  // are built for the documented word width only, and the acquire
  // counter needs at least one cycle to tell acquire from convert
  if (RES_BITS != `SARSEQ_RES_BITS || ACQ_CYC < 1) begin : g_param_check
    $error("sarseq_core: unsupported parameters");
  end

  localparam int CW = $clog2(RES_BITS + ACQ_CYC + 1);

  // two-flop synchronisers for the pins
  // both pins are asynchronous to clk_i; only the second flop is read
  // so that a metastable first stage never reaches the edge detector
  logic [1:0] cs_sync_r;
  logic [1:0] st_sync_r;
  logic       st_prev_r;                    // previous synced start level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_sync_r <= 2'b11;
      st_sync_r <= 2'b11;
      st_prev_r <= 1'b1;
    end else begin
      cs_sync_r <= {cs_sync_r[0], cs_n_i};
      st_sync_r <= {st_sync_r[0], conversion_start_n_i};
      st_prev_r <= st_sync_r[1];
    end
  end

  // accepted start: falling edge with chip select low
  logic start_req;
  assign start_req = st_prev_r & ~st_sync_r[1] & ~cs_sync_r[1];

  sarseq_state_t         state_r, state_nxt;   // phase
  logic [CW-1:0]         cnt_r, cnt_nxt;       // acquire count / bit index
  logic [RES_BITS-1:0]   approx_result_register_r, approx_nxt;
  logic [RES_BITS-1:0]   data_r, data_nxt;     // output latches
  logic                  busy_r, busy_nxt;
  logic                  samp_r, samp_nxt;     // sampling strobe
  logic                  acq_ok;               // acquire time served
  assign acq_ok = (cnt_r >= CW'(ACQ_CYC));

  // next-state logic of the sequencer
  // acquire: count settle cycles, wait for an accepted start
  // convert: one bit decision per cycle, msb down to lsb
  // load: copy the decided word to the latches, release busy
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    approx_nxt = approx_result_register_r;
    data_nxt   = data_r;
    busy_nxt   = busy_r;
    samp_nxt   = 1'b0;
    case (state_r)
      SARSEQ_ACQ: begin
        if (!acq_ok) begin
          cnt_nxt = cnt_r + CW'(1);
        end
        if (start_req && acq_ok) begin
          state_nxt  = SARSEQ_CONV;
          approx_nxt = '0;
          cnt_nxt    = CW'(RES_BITS - 1);
          busy_nxt   = 1'b0;
          samp_nxt   = 1'b1;
        end
      end
      SARSEQ_CONV: begin
        // keep trial bit when comparator says input above dac
        approx_nxt[cnt_r[$clog2(RES_BITS)-1:0]] = comp_i;
        if (cnt_r == '0) begin
          state_nxt = SARSEQ_LOAD;
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      SARSEQ_LOAD: begin
        data_nxt  = approx_result_register_r;
        busy_nxt  = 1'b1;
        cnt_nxt   = '0;
        state_nxt = SARSEQ_ACQ;
      end
      default: begin
        state_nxt = SARSEQ_ACQ;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r                  <= SARSEQ_ACQ;
      cnt_r                    <= '0;
      approx_result_register_r <= '0;
      data_r                   <= `SARSEQ_RESULT_RST;
      busy_r                   <= 1'b1;
      samp_r                   <= 1'b0;
    end else begin
      state_r                  <= state_nxt;
      cnt_r                    <= cnt_nxt;
      approx_result_register_r <= approx_nxt;
      data_r                   <= data_nxt;
      busy_r                   <= busy_nxt;
      samp_r                   <= samp_nxt;
    end
  end

  // trial word: decided bits plus current trial bit
  // registered so the dac sees a clean word for the whole cycle
  logic [RES_BITS-1:0] trial_nxt, trial_r;
  logic                zero_r;
  always_comb begin
    trial_nxt = approx_nxt;
    if (state_nxt == SARSEQ_CONV) begin
      trial_nxt[cnt_nxt[$clog2(RES_BITS)-1:0]] = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trial_r <= '0;
      zero_r  <= 1'b1;
    end else begin
      trial_r <= trial_nxt;
      zero_r  <= (state_nxt == SARSEQ_ACQ);
    end
  end

  assign busy_o        = busy_r;
  assign data_o        = data_r;
  assign ana_o.sample  = samp_r;
  assign ana_o.zeroing = zero_r;
  assign ana_o.trial   = trial_r;

  // checks
  a_start_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(samp_r) |-> approx_result_register_r == '0)
    else $error("register not cleared at start");
  // busy low for 12 convert cycles plus the load cycle, then high
  a_busy_span: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(busy_r) |-> (!busy_r) [*8] ##1 (!busy_r) [*5] ##1 busy_r)
    else $error("busy low span wrong");
  a_no_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == SARSEQ_CONV |-> !samp_r || $past(state_r) == SARSEQ_ACQ)
    else $error("restart during conversion");
  a_cs_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(samp_r) |-> $past(cs_sync_r[1]) == 1'b0)
    else $error("start without chip select");
  a_edge_start: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(samp_r) |-> $past(st_prev_r) && !$past(st_sync_r[1]))
    else $error("start not on falling edge");
  a_acq_time: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_r) |-> (!samp_r) [*3])
    else $error("acquire phase too short");
  a_zero_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == SARSEQ_CONV |-> !zero_r)
    else $error("zeroing during convert");
  a_load_data: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_r) |-> data_r == $past(approx_result_register_r))
    else $error("result not latched");
  a_msb_first: assert property (@(posedge clk_i) disable iff (rst_i)
    samp_r |-> cnt_r == CW'(RES_BITS - 1))
    else $error("first step not msb");
  a_one_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    samp_r |=> !samp_r [*8])
    else $error("extra sample strobe");
  // first trial of a conversion is the msb alone
  a_trial_first: assert property (@(posedge clk_i) disable iff (rst_i)
    samp_r |-> trial_r == {1'b1, {(RES_BITS-1){1'b0}}})
    else $error("first trial not msb");
  // latches change only when a result is loaded
  a_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !$rose(busy_r) |-> $stable(data_r))
    else $error("result latches moved");
  // busy high whenever the sequencer sits in acquire
  a_busy_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == SARSEQ_ACQ |-> busy_r)
    else $error("busy low in acquire");
  // zeroing switches closed for the whole acquire phase
  a_zero_acq: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == SARSEQ_ACQ |-> zero_r)
    else $error("zeroing off in acquire");
  // main scenarios
  c_conversion: cover property (@(posedge clk_i) $fell(busy_r) ##13 busy_r);
  c_back_to_back: cover property (@(posedge clk_i) $rose(busy_r) ##3 $fell(busy_r));
  c_ignored: cover property (@(posedge clk_i) state_r == SARSEQ_CONV && start_req);
  c_no_cs: cover property (@(posedge clk_i) st_prev_r && !st_sync_r[1] && cs_sync_r[1]);
endmodule

// ==== dv/sarseq_comp_model.sv ====
// comparator stand-in answering the sequencer's bit trials
// assumes busy_i is the sequencer's busy output on the same clock
`timescale 1ns/1ps
module sarseq_comp_model (
  input  wire logic        clk_i,    // sequencer clock
  input  wire logic        rst_i,    // sync reset, active high
  input  wire logic        busy_i,   // low while converting
  input  wire logic [11:0] target_i, // code the analog input stands for
  output logic             comp_o    // keep-bit answer
);
  logic [3:0] step_r; // bit trial index since busy fell
  logic       tog_r;  // filler that changes every cycle
  // step count and idle filler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_r <= 4'h0;
      tog_r  <= 1'b0;
    end else begin
      tog_r  <= ~tog_r;
      step_r <= busy_i ? 4'h0 : step_r + 4'h1;
    end
  end
  // answers msb first, garbage outside trials
  assign comp_o = (!busy_i && step_r < 4'hC) ? target_i[4'hB - step_r] : tog_r;
endmodule

// ==== dv/tb_top.sv ====
// directed bench for the conversion sequencer
// assumes the package and core are compiled first
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cs_n = 1'b1, start_n = 1'b1, comp;
  logic busy_o;
  logic [11:0] data_o, target = 12'h000;
  sarseq_pkg::sarseq_ana_t ana_o;
  int bad_count = 0, total_checks = 0;
  sarseq_core i_sarseq_core (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n),
    .conversion_start_n_i(start_n), .comp_i(comp), .busy_o(busy_o), .data_o(data_o),
    .ana_o(ana_o));
  sarseq_comp_model i_sarseq_comp_model (.clk_i(clk_i), .rst_i(rst_i), .busy_i(busy_o),
    .target_i(target), .comp_o(comp));
  // 25 ns clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin bad_count++; $display("[FAIL] %0t %s", $time, what); end
  endtask
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin bad_count++; $display("[FAIL] %0t data %h", $time, got); end
  endtask
  task automatic chk_int(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin bad_count++; $display("[FAIL] %0t %s %0d", $time, what, got); end
  endtask
  // busy must stay high for n cycles
  task automatic quiet(input int n);
    repeat (n) begin @(posedge clk_i); #1; chk_bit(busy_o, 1'b1, "stray start"); end
  endtask
  // one conversion request; poke restarts mid-run
  task automatic conv(input logic [11:0] tgt, input logic csn, input bit poke);
    int w, n;
    @(posedge clk_i); target <= tgt; cs_n <= csn;
    @(posedge clk_i); start_n <= 1'b0;
    @(posedge clk_i); start_n <= 1'b1;
    #1; w = 0;
    while (busy_o !== 1'b0 && w < 10) begin @(posedge clk_i); #1; w++; end
    if (csn) begin chk_bit(busy_o, 1'b1, "cs high start"); quiet(10); return; end
    if (w == 10) begin chk_int(w, 0, "no start"); stop_test(); end
    chk_bit(ana_o.sample, 1'b1, "sample");
    chk_bit(ana_o.zeroing, 1'b0, "zeroing");
    chk_word(ana_o.trial, 12'h800);
    n = 0;
    while (busy_o === 1'b0 && n < 20) begin
      @(posedge clk_i); if (poke) start_n <= (n != 3); #1; n++;
      if (busy_o === 1'b0) chk_bit(ana_o.zeroing, 1'b0, "zero in conv");
    end
    chk_int(n, 13, "busy len");
    chk_word(data_o, tgt);
    @(posedge clk_i); #1; chk_bit(ana_o.zeroing, 1'b1, "zero back");
    if (poke) quiet(10);
    $display("test conv %h done", tgt);
  endtask
  initial begin
    logic [11:0] tbl [6] = '{12'hFFF, 12'h000, 12'hA5C, 12'h800, 12'h7FF, 12'h001};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1; chk_bit(busy_o, 1'b1, "rst busy"); chk_word(data_o, 12'h000);
    chk_bit(ana_o.zeroing, 1'b1, "rst zero"); chk_bit(ana_o.sample, 1'b0, "rst smp");
    $display("test reset done");
    foreach (tbl[i]) conv(tbl[i], 1'b0, 1'b0);
    conv(12'h3C6, 1'b1, 1'b0);
    chk_word(data_o, 12'h001);
    $display("test cs high done");
    conv(12'h5A3, 1'b0, 1'b1);
    conv(12'hC35, 1'b0, 1'b0);
    stop_test();
  end
endmodule
